/* core/rla_pkg.sv */
package rla_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SEL = 8'h04;
    localparam logic [7:0] OFF_SEL_HI = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN = 8'h14;

    // control register fields
    localparam int CTRL_LOSS_ACT_BIT = 0;
    localparam int CTRL_CONTACT_SEL_BIT = 1;
    localparam int CTRL_MPL_LSB = 2;
    localparam int CTRL_LIMIT_LSB = 4;
    localparam int CTRL_FRESET_BIT = 8;

    // reset values and the limit ceiling
    localparam logic RST_LOSS_ACT = 1'b0;
    localparam logic RST_CONTACT_SEL = 1'b0;
    localparam logic [3:0] RST_LIMIT = 4'h0;
    localparam logic [3:0] LIMIT_MAX = 4'hA;
    localparam logic [1:0] RST_MPL = 2'h0;

    // contact output function codes
    localparam logic [7:0] FN_REF_LOST = 8'h0C;
    localparam logic [7:0] FN_AUTO_RESTART = 8'h1E;
    localparam int NUM_CONTACTS = 5;

    // fault code bit positions
    localparam int FLT_OC = 0;
    localparam int FLT_GF = 1;
    localparam int FLT_FUSE = 2;
    localparam int FLT_OV = 3;
    localparam int FLT_UV = 4;
    localparam int FLT_SUPPLY = 5;
    localparam int FLT_PHASE = 6;
    localparam int FLT_W = 16;

    // interrupt bits
    localparam int IRQ_REF_LOSS = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_TRIP = 2;
    localparam int IRQ_W = 3;

    // timing
    localparam longint CLK_HZ = 250_000_000;
    localparam longint WIN_MS = 400;
    localparam longint WIN_CYC = CLK_HZ * WIN_MS / 1000;
    localparam longint GOOD_MIN = 10;
    localparam longint GOOD_CYC = CLK_HZ * GOOD_MIN * 60;
    localparam int LOSS_PCT = 90;
    localparam int HOLD_PCT = 80;
    localparam int DIAG_CYC = 16;

    typedef enum logic [2:0] {
        RS_RUN,
        RS_DIAG,
        RS_SEARCH,
        RS_TRIP
    } rla_state_e;

    typedef struct packed {
        logic lossAct;
        logic contactSel;
        logic [1:0] mplSel;
        logic [3:0] limit;
    } rla_cfg_s;

endpackage

/* core/ref_loss_and_auto_restart.sv */
`timescale 1ns/1ps
module ref_loss_and_auto_restart #(
    parameter int REF_W = 16,
    parameter longint WIN_CYCLES = rla_pkg::WIN_CYC,
    parameter longint GOOD_CYCLES = rla_pkg::GOOD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [REF_W-1:0] refIn,
    input wire logic running,
    input wire logic faultStb,
    input wire logic [rla_pkg::FLT_W-1:0] faultCode,
    input wire logic diagDone,
    input wire logic diagError,
    input wire logic searchDone,
    output logic [REF_W-1:0] speedCmd,
    output logic searchReq,
    output logic [REF_W-1:0] searchFreq,
    output logic faultContact,
    output logic [rla_pkg::NUM_CONTACTS-1:0] contactOut,
    output logic irq
);

    localparam int WIN_W = $clog2(WIN_CYCLES + 1);
    localparam int GOOD_W = $clog2(GOOD_CYCLES + 1);

    typedef struct packed {
        rla_pkg::rla_cfg_s cfg;
        logic [rla_pkg::NUM_CONTACTS-1:0][7:0] fnSel;
        logic [rla_pkg::IRQ_W-1:0] irqStat;
        logic [rla_pkg::IRQ_W-1:0] irqEn;
        rla_pkg::rla_state_e st;
        logic [WIN_W-1:0] winCnt;
        logic [REF_W-1:0] winStart;
        logic [REF_W-1:0] lastGood;
        logic lost;
        logic [3:0] attempts;
        logic [GOOD_W-1:0] goodCnt;
        logic goodArm;
        logic [REF_W-1:0] faultFreq;
        logic [REF_W-1:0] speedCmd;
        logic searchReq;
        logic faultContact;
        logic [rla_pkg::NUM_CONTACTS-1:0] contactOut;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rla_state_s;

    rla_state_s s_q, s_d;

    // true when cur is at most ten percent of start
    function automatic logic collapsed(input logic [REF_W-1:0] start,
                                       input logic [REF_W-1:0] cur);
        logic [REF_W+7:0] lhs;
        logic [REF_W+7:0] rhs;
        lhs = (REF_W+8)'(cur) * (REF_W+8)'(100);
        rhs = (REF_W+8)'(start) * (REF_W+8)'(100 - rla_pkg::LOSS_PCT);
        return (start != '0) && (lhs <= rhs);
    endfunction

    function automatic logic [REF_W-1:0] pct(input logic [REF_W-1:0] v,
                                             input int p);
        logic [REF_W+7:0] m;
        m = (REF_W+8)'(v) * (REF_W+8)'(p);
        return REF_W'(m / (REF_W+8)'(100));
    endfunction

    function automatic logic retryable(input logic [rla_pkg::FLT_W-1:0] f,
                                       input logic [1:0] mpl);
        logic r;
        r = f[rla_pkg::FLT_OC] | f[rla_pkg::FLT_GF] | f[rla_pkg::FLT_FUSE]
            | f[rla_pkg::FLT_OV] | f[rla_pkg::FLT_SUPPLY]
            | f[rla_pkg::FLT_PHASE];
        if (f[rla_pkg::FLT_UV])
        begin
            r = r | (mpl == 2'h1) | (mpl == 2'h2);
        end
        // any other fault bit forces a protective trip
        if ((f & ~rla_pkg::FLT_W'(7'h7F)) != '0)
        begin
            r = 1'b0;
        end
        return r;
    endfunction

    // every offset that answers without an error
    function automatic logic reg_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == rla_pkg::OFF_CTRL || a == rla_pkg::OFF_SEL
            || a == rla_pkg::OFF_SEL_HI || a == rla_pkg::OFF_STATUS)
        begin
            hit = 1'b1;
        end
        else if (a == rla_pkg::OFF_IRQ_STAT || a == rla_pkg::OFF_IRQ_CLR
                 || a == rla_pkg::OFF_IRQ_EN)
        begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    logic apbWr;
    logic apbRd;
    logic [rla_pkg::IRQ_W-1:0] events;
    logic [rla_pkg::IRQ_W-1:0] clrMask;
    logic fresetWr;
    logic restarting;

    always_comb
    begin
        s_d = s_q;
        apbWr = psel && penable && pwrite && !s_q.pready;
        apbRd = psel && penable && !pwrite && !s_q.pready;
        events = '0;
        clrMask = '0;
        fresetWr = 1'b0;
        // a write lands on the first access edge, pready answers a cycle later
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;

        // register writes
        if (apbWr)
        begin
            if (paddr == rla_pkg::OFF_CTRL)
            begin
                s_d.cfg.lossAct = pwdata[rla_pkg::CTRL_LOSS_ACT_BIT];
                s_d.cfg.contactSel = pwdata[rla_pkg::CTRL_CONTACT_SEL_BIT];
                s_d.cfg.mplSel = pwdata[rla_pkg::CTRL_MPL_LSB +: 2];
                // out-of-range limits saturate at ten
                if (pwdata[rla_pkg::CTRL_LIMIT_LSB +: 4] > rla_pkg::LIMIT_MAX)
                begin
                    s_d.cfg.limit = rla_pkg::LIMIT_MAX;
                end
                else
                begin
                    s_d.cfg.limit = pwdata[rla_pkg::CTRL_LIMIT_LSB +: 4];
                end
                fresetWr = pwdata[rla_pkg::CTRL_FRESET_BIT];
            end
            else if (paddr == rla_pkg::OFF_SEL)
            begin
                s_d.fnSel[3:0] = pwdata;
            end
            else if (paddr == rla_pkg::OFF_SEL_HI)
            begin
                // five byte selects do not fit one word, the fifth sits here
                s_d.fnSel[4] = pwdata[7:0];
            end
            else if (paddr == rla_pkg::OFF_IRQ_CLR)
            begin
                clrMask = pwdata[rla_pkg::IRQ_W-1:0];
            end
            else if (paddr == rla_pkg::OFF_IRQ_EN)
            begin
                s_d.irqEn = pwdata[rla_pkg::IRQ_W-1:0];
            end
            else if (!reg_mapped(paddr))
            begin
                s_d.pslverr = 1'b1;
            end
        end

        // register reads
        if (apbRd)
        begin
            s_d.prdata = '0;
            if (paddr == rla_pkg::OFF_CTRL)
            begin
                s_d.prdata[rla_pkg::CTRL_LOSS_ACT_BIT] = s_q.cfg.lossAct;
                s_d.prdata[rla_pkg::CTRL_CONTACT_SEL_BIT] = s_q.cfg.contactSel;
                s_d.prdata[rla_pkg::CTRL_MPL_LSB +: 2] = s_q.cfg.mplSel;
                s_d.prdata[rla_pkg::CTRL_LIMIT_LSB +: 4] = s_q.cfg.limit;
            end
            else if (paddr == rla_pkg::OFF_SEL)
            begin
                s_d.prdata = s_q.fnSel[3:0];
            end
            else if (paddr == rla_pkg::OFF_SEL_HI)
            begin
                s_d.prdata[7:0] = s_q.fnSel[4];
            end
            else if (paddr == rla_pkg::OFF_STATUS)
            begin
                s_d.prdata[0] = s_q.lost;
                s_d.prdata[3:1] = 3'(s_q.st);
                s_d.prdata[11:8] = s_q.attempts;
            end
            else if (paddr == rla_pkg::OFF_IRQ_STAT)
            begin
                s_d.prdata[rla_pkg::IRQ_W-1:0] = s_q.irqStat;
            end
            else if (paddr == rla_pkg::OFF_IRQ_EN)
            begin
                s_d.prdata[rla_pkg::IRQ_W-1:0] = s_q.irqEn;
            end
            else if (!reg_mapped(paddr))
            begin
                s_d.pslverr = 1'b1;
            end
        end

        // reference collapse watch: a new window starts every 400 ms
        // from the current level, so a slow drift never declares loss
        // refIn is taken as a sample of this clock; a source from another
        // domain needs its own synchroniser ahead of this block
        if (s_q.winCnt >= WIN_W'(WIN_CYCLES - 1))
        begin
            s_d.winCnt = '0;
            s_d.winStart = refIn;
        end
        else
        begin
            s_d.winCnt = s_q.winCnt + WIN_W'(1);
        end
        if (!s_q.lost && collapsed(s_q.winStart, refIn))
        begin
            s_d.lost = 1'b1;
            events[rla_pkg::IRQ_REF_LOSS] = 1'b1;
        end
        else if (s_q.lost && !collapsed(s_q.lastGood, refIn))
        begin
            // reference back above the collapse level
            s_d.lost = 1'b0;
        end
        if (!s_q.lost)
        begin
            s_d.lastGood = s_q.winStart;
        end

        if (s_q.lost && s_q.cfg.lossAct)
        begin
            s_d.speedCmd = pct(s_q.lastGood, rla_pkg::HOLD_PCT);
        end
        else
        begin
            s_d.speedCmd = refIn;
        end

        // auto restart sequencer
        case (s_q.st)
            rla_pkg::RS_RUN:
            begin
                if (faultStb)
                begin
                    s_d.faultFreq = s_q.speedCmd;
                    s_d.st = rla_pkg::RS_DIAG;
                    s_d.goodArm = 1'b0;
                end
                else if (s_q.goodArm && running)
                begin
                    if (s_q.goodCnt >= GOOD_W'(GOOD_CYCLES - 1))
                    begin
                        s_d.attempts = '0;
                        s_d.goodArm = 1'b0;
                    end
                    else
                    begin
                        s_d.goodCnt = s_q.goodCnt + GOOD_W'(1);
                    end
                end
            end
            rla_pkg::RS_DIAG:
            begin
                if (diagDone)
                begin
                    if (!diagError && retryable(faultCode, s_q.cfg.mplSel)
                        && s_q.attempts < s_q.cfg.limit)
                    begin
                        s_d.attempts = s_q.attempts + 4'h1;
                        s_d.st = rla_pkg::RS_SEARCH;
                        s_d.searchReq = 1'b1;
                        events[rla_pkg::IRQ_RESTART] = 1'b1;
                    end
                    else
                    begin
                        s_d.st = rla_pkg::RS_TRIP;
                        events[rla_pkg::IRQ_TRIP] = 1'b1;
                    end
                end
            end
            rla_pkg::RS_SEARCH:
            begin
                if (searchDone)
                begin
                    s_d.searchReq = 1'b0;
                    s_d.st = rla_pkg::RS_RUN;
                    s_d.goodArm = 1'b1;
                    s_d.goodCnt = '0;
                end
            end
            rla_pkg::RS_TRIP:
            begin
                if (fresetWr)
                begin
                    s_d.attempts = '0;
                    s_d.st = rla_pkg::RS_RUN;
                end
            end
            default:
            begin
                s_d.st = rla_pkg::RS_RUN;
            end
        endcase

        restarting = (s_q.st == rla_pkg::RS_DIAG)
            || (s_q.st == rla_pkg::RS_SEARCH);
        s_d.faultContact = (s_q.st == rla_pkg::RS_TRIP)
            || (restarting && s_q.cfg.contactSel);
        for (int i = 0; i < rla_pkg::NUM_CONTACTS; i++)
        begin
            s_d.contactOut[i] =
                ((s_q.fnSel[i] == rla_pkg::FN_REF_LOST) && s_q.lost)
                || ((s_q.fnSel[i] == rla_pkg::FN_AUTO_RESTART)
                    && restarting);
        end

        // set wins over a same-cycle clear
        s_d.irqStat = (s_q.irqStat & ~clrMask) | events;
        s_d.irq = |(s_q.irqStat & s_q.irqEn);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.cfg.lossAct <= rla_pkg::RST_LOSS_ACT;
            s_q.cfg.contactSel <= rla_pkg::RST_CONTACT_SEL;
            s_q.cfg.mplSel <= rla_pkg::RST_MPL;
            s_q.cfg.limit <= rla_pkg::RST_LIMIT;
            s_q.attempts <= 4'h0;
            s_q.st <= rla_pkg::RS_RUN;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign speedCmd = s_q.speedCmd;
    assign searchReq = s_q.searchReq;
    assign searchFreq = s_q.faultFreq;
    assign faultContact = s_q.faultContact;
    assign contactOut = s_q.contactOut;
    assign irq = s_q.irq;

endmodule // ref_loss_and_auto_restart

/* bench/rla_chk.sv */
`timescale 1ns/1ps
module rla_chk #(
    parameter int REF_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [REF_W-1:0] refIn,
    input wire logic faultStb,
    input wire logic [rla_pkg::FLT_W-1:0] faultCode,
    input wire logic searchReq,
    input wire logic searchDone,
    input wire logic [REF_W-1:0] searchFreq,
    input wire logic [REF_W-1:0] speedCmd,
    input wire logic faultContact
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic act_q, sel_q, nr_q;
    logic [1:0] mpl_q;
    logic [3:0] lim_q;
    logic [REF_W-1:0] fq_q;
    wire ctrlWr = psel && penable && pready && pwrite && paddr == 8'h00;
    // blind to the diagnosis result, so for single-bit fault codes it only flags sure trips
    wire noRetry = |faultCode[15:7] || lim_q == 4'h0 ||
        (faultCode[4] && !(mpl_q inside {2'h1, 2'h2}));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {act_q, sel_q, nr_q, mpl_q, lim_q} <= '0;
            fq_q <= '0;
        end
        else
        begin
            if (ctrlWr)
            begin
                {mpl_q, sel_q, act_q} <= pwdata[3:0];
                lim_q <= (pwdata[7:4] > 4'hA) ? 4'hA : pwdata[7:4];
            end
            if (ctrlWr && pwdata[8])
                nr_q <= 1'b0;
            else if (faultStb && !searchReq && noRetry)
                nr_q <= 1'b1;
            if (faultStb && !searchReq)
                fq_q <= speedCmd;
        end
    end
    rdy_late_a: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered one cycle after it began");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    err_map_a: assert property (pslverr |-> pready && !(paddr inside
        {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18}))
        else $error("error response on a mapped address");
    follow_ref_a: assert property (
        !act_q && $past(rst_n) && $past(rst_n, 2) |->
        speedCmd == $past(refIn)) else $error("speed does not follow ref");
    srch_freq_a: assert property (searchReq |-> searchFreq == fq_q)
        else $error("search frequency differs from the one at the fault");
    srch_stay_a: assert property (
        searchReq && !searchDone |=> searchReq)
        else $error("search request dropped before search done");
    srch_end_a: assert property (
        searchReq && searchDone |=> !searchReq)
        else $error("search request kept after search done");
    contact_quiet_a: assert property (
        searchReq && !sel_q |-> !faultContact)
        else $error("fault contact active during a quiet restart");
    no_restart_a: assert property (nr_q |-> !searchReq)
        else $error("restart started after a non-retryable fault");
    cover property ($rose(searchReq));
    cover property (nr_q && faultContact);
    cover property (pready && pslverr);
endmodule // rla_chk

/* bench/rla_plant.sv */
`timescale 1ns/1ps
module rla_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic faultStb,
    input wire logic searchReq,
    input wire logic [3:0] dly,
    input wire logic errSet,
    output logic diagDone,
    output logic diagError,
    output logic searchDone
);
    logic [3:0] diag_q;
    logic [3:0] srch_q;
    logic req_q;
    // error line wanders outside diagDone to catch early sampling
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {diag_q, srch_q, req_q} <= '0;
            {diagDone, diagError, searchDone} <= '0;
        end
        else
        begin
            diagDone <= diag_q == 4'h1;
            diagError <= (diag_q == 4'h1) ? errSet : ~diagError;
            searchDone <= srch_q == 4'h1;
            req_q <= searchReq;
            diag_q <= faultStb ? dly : diag_q - {3'h0, diag_q != 4'h0};
            srch_q <= (searchReq && !req_q) ? dly :
                srch_q - {3'h0, srch_q != 4'h0};
        end
    end
endmodule // rla_plant

/* bench/ref_loss_and_auto_restart_tb.sv */
`timescale 1ns/1ps
module ref_loss_and_auto_restart_tb;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } rla_row_s;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, running = 1'b1, faultStb = 1'b0, errSet = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
    logic pready, pslverr, rerr, diagDone, diagError, searchDone;
    logic searchReq, faultContact, irq;
    logic [15:0] refIn = 16'h0000, faultCode = 16'h0000;
    logic [15:0] speedCmd, searchFreq;
    logic [4:0] contactOut;
    logic [3:0] dly = 4'h6;
    int n_errors = 0, n_checks = 0;
    rla_row_s rows[7] = '{
        '{8'h00, 32'h0000_00F1, 32'h0000_00A1, 1'b0},
        '{8'h00, 32'h0000_01A1, 32'h0000_00A1, 1'b0},
        '{8'h04, 32'h1E0C_1E0C, 32'h1E0C_1E0C, 1'b0},
        '{8'h18, 32'h0000_000C, 32'h0000_000C, 1'b0},
        '{8'h08, 32'h0000_FFFF, 32'h0000_0000, 1'b0},
        '{8'h14, 32'h0000_0007, 32'h0000_0007, 1'b0},
        '{8'h40, 32'h0000_0001, 32'h0000_0000, 1'b1}};
    logic [7:0] tcCtrl[5] = '{8'hA0, 8'hA0, 8'hA0, 8'h00, 8'hAC};
    int tcBit[5] = '{4, 9, 0, 0, 4};
    logic tcErr[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    always #2 clk = ~clk;
    ref_loss_and_auto_restart #(.WIN_CYCLES(100), .GOOD_CYCLES(200)) i_dut (.*);
    rla_plant i_plant (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20)
            n_errors++;
    endtask
    task automatic ref_step(input logic [15:0] v);
        @(posedge clk);
        refIn <= v;
        repeat (250) @(posedge clk);
    endtask
    task automatic flt(input int b, input logic rs, input logic fc);
        int n;
        @(posedge clk);
        {faultCode, faultStb} <= {16'h0001 << b, 1'b1};
        @(posedge clk);
        faultStb <= 1'b0;
        for (n = 0; searchReq !== 1'b1 && n < 40; n++)
            @(posedge clk);
        chk(searchReq, rs);
        if (rs)
        begin
            repeat (2) @(posedge clk);
            chk(searchFreq, 16'h03E8);
            chk(contactOut[1], 1'b1);
            chk(faultContact, fc);
            for (n = 0; searchReq !== 1'b0 && n < 40; n++)
                @(posedge clk);
            chk(searchReq, 1'b0);
        end
    endtask
    task automatic end_sim;
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #40_000;
        n_errors++;
        end_sim;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk(rerr, rows[i].e);
            if (!rows[i].e)
                chk(rdat, rows[i].x);
        end
        apb(1'b1, 8'h14, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_00A0);
        ref_step(16'h03E8);
        ref_step(16'h0065);
        chk(contactOut[0], 1'b0);
        ref_step(16'h03E8);
        ref_step(16'h0064);
        chk(contactOut[0], 1'b1);
        chk(contactOut[2], 1'b1);
        chk(contactOut[4], 1'b1);
        chk(speedCmd, 16'h0064);
        chk(irq, 1'b0);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat[0], 1'b1);
        apb(1'b1, 8'h14, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        ref_step(16'h03E8);
        apb(1'b1, 8'h10, 32'h0000_0007);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        chk(contactOut[0], 1'b0);
        chk(contactOut[4], 1'b0);
        apb(1'b1, 8'h00, 32'h0000_00A1);
        ref_step(16'h0064);
        chk(speedCmd, 16'h0320);
        ref_step(16'h03E8);
        apb(1'b1, 8'h14, 32'h0000_0004);
        apb(1'b1, 8'h00, 32'h0000_0020);
        flt(0, 1'b1, 1'b0);
        flt(1, 1'b1, 1'b0);
        flt(3, 1'b0, 1'b0);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat, 32'h0000_0206);
        chk(irq, 1'b1);
        apb(1'b1, 8'h00, 32'h0000_0120);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_00A6);
        for (int i = 0; i < 7; i++)
            flt(i, 1'b1, 1'b1);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat, 32'h0000_0700);
        repeat (210) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        dly <= 4'h1;
        foreach (tcCtrl[i])
        begin
            apb(1'b1, 8'h00, {24'h00_0001, tcCtrl[i]});
            errSet <= tcErr[i];
            flt(tcBit[i], 1'b0, 1'b0);
            apb(1'b0, 8'h08, 32'h0000_0000);
            chk(rdat[3:1], 3'h3);
        end
        errSet <= 1'b0;
        dly <= 4'h6;
        apb(1'b1, 8'h00, 32'h0000_0128);
        flt(4, 1'b1, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk(rdat, 32'h0000_0000);
        end_sim;
    end
endmodule // ref_loss_and_auto_restart_tb
bind ref_loss_and_auto_restart rla_chk #(.REF_W(REF_W)) i_chk (.*);
